// ==== rtl/hbw_regs.sv ====
`timescale 1ns/1ps
`include "hbw_map.svh"
// Behaviour
// (RL1) Width bit at bytes 0,1 and word 0
// (RL2) Width write works in either bus width
// (RL3) Reset clears width bit: byte mode
// (RL4) Byte mode: full address, data 7:0
// (RL5) Word mode: address 6:1, all data
// (RL6) Status at bytes 4-7, words 2-3
// (RL7) Host reads status to find interrupt source
// (RL8) Status bit 0: config engine holds lock
// (RL9) Status bit 1: host port holds lock
// (RL10) Status bit 2: config engine fault
// (RL11) Status bit 3: card engine fault
// (RL12) Read-only fault detail from byte 8
// (RL13) At most one lock owner at once
module hbw_regs (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  // Host port pins
  input  wire logic [6:0]  i_mpu_addr,
  input  wire logic [15:0] i_mpu_data,
  output logic      [15:0] o_mpu_data,
  output logic             o_mpu_data_oe_lo,
  output logic             o_mpu_data_oe_hi,
  input  wire logic        i_mpu_ce_n,
  input  wire logic        i_mpu_oe_n,
  input  wire logic        i_mpu_we_n,
  // Lock requests from engines
  input  wire logic        i_cfg_lock_req,
  input  wire logic        i_host_lock_req,
  // Engine fault levels
  input  wire logic        i_cfg_fault,
  input  wire logic        i_card_fault,
  input  wire logic [31:0] i_fault_detail,
  // Width setting for the rest of the host port
  output logic             o_wide_bus_bit
);

  hbw_pkg::hbw_regs_st_t st;       // Registered state
  hbw_pkg::hbw_regs_st_t next_st;  // Next state

  hbw_lock_if lock ();             // Lock handshake

  // Decode terms, all from second sync stage
  logic        rd_act;             // Chip and output enables low
  logic        wr_act;             // Chip and write enables low
  logic        wr_edge;            // First cycle of a write
  logic [6:0]  byte_addr;          // Address as bytes
  logic [4:0]  reg_idx;            // 32-bit register index
  logic        width_hit;          // Access hits the width bit
  logic [31:0] reg_val;            // Addressed register
  logic [15:0] rd_half;            // Addressed half word
  logic [7:0]  rd_byte;            // Addressed byte

  // Arbiter for the card-controller lock
  hbw_lock_arb u_arb (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .lock      (lock)
  );

  // Engine requests straight onto the handshake
  assign lock.cfg_req  = i_cfg_lock_req;
  assign lock.host_req = i_host_lock_req;

  // Strobe decode; strobes are active low
  assign rd_act  = !st.ctl_s2[2] && !st.ctl_s2[1];
  assign wr_act  = !st.ctl_s2[2] && !st.ctl_s2[0];
  // Act once per strobe so a long write is one write
  assign wr_edge = wr_act && !st.wr_prev;

  // Address view follows the current width
  always_comb begin
    if (st.wide) begin
      // Word mode: address line 0 ignored
      byte_addr = {st.addr_s2[6:1], 1'b0}; // RL5
    end else begin
      // Byte mode: every line decoded
      byte_addr = st.addr_s2; // RL4
    end
  end

  assign reg_idx   = byte_addr[6:2];
  // Bytes 0 and 1 and word 0 all land here; byte 1 is an alias, not
  // the upper half of a wider register, so only bit 1 is tested below
  assign width_hit = (reg_idx == `HBW_IDX_WIDTH) && !byte_addr[1]; // RL1

  // Register select, by index
  always_comb begin
    if (reg_idx == `HBW_IDX_WIDTH) begin
      reg_val = {31'h0, st.wide};
    end else if (reg_idx == `HBW_IDX_STATUS) begin
      reg_val = st.stat; // RL6
    end else if (reg_idx == `HBW_IDX_FAULT) begin
      reg_val = st.fault; // RL12
    end else begin
      // Unmapped and reserved read as zero
      reg_val = 32'h0;
    end
  end

  // Lane select within the register
  always_comb begin
    if (byte_addr[1]) begin
      rd_half = reg_val[31:16];
    end else begin
      rd_half = reg_val[15:0];
    end
    case (byte_addr[1:0])
      2'h0: begin
        rd_byte = reg_val[7:0];
      end
      2'h1: begin
        rd_byte = reg_val[15:8];
      end
      2'h2: begin
        rd_byte = reg_val[23:16];
      end
      default: begin
        rd_byte = reg_val[31:24];
      end
    endcase
    // Byte 1 answers with the same bit as byte 0, so a byte host
    // reads back what it wrote through either alias
    if (width_hit) begin
      rd_byte = {7'h00, st.wide}; // RL1
    end
  end

  // Next-state logic for the whole front end
  always_comb begin
    next_st = st;
    // Pins are asynchronous: two flops before use
    next_st.addr_s1 = i_mpu_addr;
    next_st.addr_s2 = st.addr_s1;
    next_st.din_s1  = i_mpu_data;
    next_st.din_s2  = st.din_s1;
    next_st.ctl_s1  = {i_mpu_ce_n, i_mpu_oe_n, i_mpu_we_n};
    next_st.ctl_s2  = st.ctl_s1;
    next_st.wr_prev = wr_act;

    // Width bit sits on data line 0 in both widths
    if (wr_edge && width_hit) begin
      next_st.wide = st.din_s2[`HBW_BIT_WIDE]; // RL1 RL2
    end

    // Status is live; no sticky bits
    next_st.stat = 32'h0;
    next_st.stat[`HBW_BIT_CFG_OWN]    = lock.cfg_own;   // RL8
    next_st.stat[`HBW_BIT_HOST_OWN]   = lock.host_own;  // RL9
    next_st.stat[`HBW_BIT_CFG_FAULT]  = i_cfg_fault;    // RL10
    next_st.stat[`HBW_BIT_CARD_FAULT] = i_card_fault;   // RL11

    // Fault detail tracks the engines, host cannot write it
    next_st.fault = i_fault_detail; // RL12

    // Read data and lane enables
    next_st.oe_lo = rd_act;
    next_st.oe_hi = rd_act && st.wide; // RL4 RL5
    if (!rd_act) begin
      next_st.dout = 16'h0;
    end else if (st.wide) begin
      next_st.dout = rd_half; // RL5 RL6
    end else begin
      // Upper lines stay undriven in byte mode
      next_st.dout = {8'h00, rd_byte}; // RL4 RL6
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st.addr_s1 <= 7'h00;
      st.addr_s2 <= 7'h00;
      st.din_s1  <= 16'h0000;
      st.din_s2  <= 16'h0000;
      // Strobes idle high so reset looks like no access
      st.ctl_s1  <= `HBW_RST_CTL;
      st.ctl_s2  <= `HBW_RST_CTL;
      st.wr_prev <= 1'b0;
      st.wide    <= `HBW_RST_WIDE; // RL3
      st.stat    <= 32'h0;
      st.fault   <= 32'h0;
      st.dout    <= 16'h0000;
      st.oe_lo   <= 1'b0;
      st.oe_hi   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs, all from flops
  assign o_mpu_data       = st.dout;
  assign o_mpu_data_oe_lo = st.oe_lo;
  assign o_mpu_data_oe_hi = st.oe_hi;
  assign o_wide_bus_bit   = st.wide;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  // Steps of a host access
  sequence s_width_write;
    wr_edge && width_hit;
  endsequence

  sequence s_byte_read(logic [6:0] a);
    rd_act && !st.wide && (st.addr_s2 == a);
  endsequence

  sequence s_word_read(logic [5:0] w);
    rd_act && st.wide && (st.addr_s2[6:1] == w);
  endsequence

  a_reset_narrow: assert property ($past(!i_nrst) |-> !o_wide_bus_bit) // RL3
    else $error("width bit not cleared by reset");

  a_alias_write: assert property (
    s_width_write |=> o_wide_bus_bit == $past(st.din_s2[0])) // RL1
    else $error("width alias write not taken");

  a_word_write: assert property (
    (wr_edge && st.wide && st.addr_s2[6:1] == 6'h00)
      |=> o_wide_bus_bit == $past(st.din_s2[0])) // RL2
    else $error("width write lost in word mode");

  a_width_kept: assert property (
    !(wr_edge && width_hit) |=> $stable(o_wide_bus_bit)) // RL1
    else $error("width bit changed without its write");

  a_byte_lanes: assert property (
    (o_mpu_data_oe_lo && !o_mpu_data_oe_hi) |-> o_mpu_data[15:8] == 8'h00) // RL4
    else $error("upper data lines used in byte mode");

  a_upper_lane: assert property (o_mpu_data_oe_hi |-> $past(st.wide)) // RL4
    else $error("upper lane driven outside word mode");

  a_word_status: assert property (
    s_word_read(`HBW_WORD_STAT_LO) |=> o_mpu_data == $past(st.stat[15:0])
      && o_mpu_data_oe_hi) // RL5
    else $error("word read of status low half wrong");

  a_byte_status: assert property (
    s_byte_read(7'h07) |=> o_mpu_data[7:0] == $past(st.stat[31:24])) // RL6
    else $error("byte read of status top byte wrong");

  a_status_hi: assert property (
    s_word_read(`HBW_WORD_STAT_HI) |=> o_mpu_data == $past(st.stat[31:16])) // RL6
    else $error("word read of status high half wrong");

  a_lock_bits: assert property (
    ##1 st.stat[1:0] == $past({lock.host_own, lock.cfg_own})) // RL8 RL9
    else $error("lock status bits do not follow grants");

  a_fault_bits: assert property (
    ##1 st.stat[3:2] == $past({i_card_fault, i_cfg_fault})) // RL10 RL11
    else $error("fault status bits do not follow engines");

  a_fault_read: assert property (
    s_byte_read(`HBW_OFS_FAULT) ##1 1'b1
      |-> o_mpu_data[7:0] == $past(st.fault[7:0])) // RL12
    else $error("fault detail byte read wrong");

  a_never_both: assert property (!(st.stat[0] && st.stat[1])) // RL13
    else $error("status shows two lock owners");

  // Read path: the answer lands one edge after the synced strobe is
  // decoded, so every check below looks one cycle on with |=>

  // A read seen on the synced strobes
  sequence s_any_read;
    rd_act;
  endsequence

  // No read on the synced strobes
  sequence s_no_read;
    !rd_act;
  endsequence

  a_read_drives: assert property (s_any_read |=> o_mpu_data_oe_lo) // RL4 RL5
    else $error("low data lane not driven during a read");

  // Lanes must go quiet so the host can own the bus again
  a_idle_quiet: assert property (
    s_no_read |=> !o_mpu_data_oe_lo && !o_mpu_data_oe_hi
      && o_mpu_data == 16'h0000) // RL4
    else $error("data lanes active without a read");

  a_byte_alias_rd: assert property (
    s_byte_read(7'h01) |=> o_mpu_data[7:0] == {7'h00, $past(st.wide)}) // RL1
    else $error("width alias byte read wrong");

  a_word_width_rd: assert property (
    s_word_read(6'h00) |=> o_mpu_data == {15'h0000, $past(st.wide)}) // RL1
    else $error("word read of width bit wrong");

  a_byte_status_lo: assert property (
    s_byte_read(`HBW_OFS_STATUS) |=> o_mpu_data[7:0] == $past(st.stat[7:0])) // RL6
    else $error("byte read of status low byte wrong");

  a_word_fault: assert property (
    s_word_read(6'h04) |=> o_mpu_data == $past(st.fault[15:0])) // RL12
    else $error("word read of fault detail low half wrong");

  a_fault_hi: assert property (
    s_word_read(6'h05) |=> o_mpu_data == $past(st.fault[31:16])) // RL12
    else $error("word read of fault detail high half wrong");

endmodule

// ==== rtl/hbw_map.svh ====
`ifndef HBW_MAP_SVH
`define HBW_MAP_SVH

// Byte offsets of the host-port registers
`define HBW_OFS_WIDTH      7'h00
`define HBW_OFS_STATUS     7'h04
`define HBW_OFS_FAULT      7'h08

// Register index, byte offset bits 6:2
`define HBW_IDX_WIDTH      5'h00
`define HBW_IDX_STATUS     5'h01
`define HBW_IDX_FAULT      5'h02

// Word-mode locations of the status halves
`define HBW_WORD_STAT_LO   6'h02
`define HBW_WORD_STAT_HI   6'h03

// Field positions
`define HBW_BIT_WIDE       0
`define HBW_BIT_CFG_OWN    0
`define HBW_BIT_HOST_OWN   1
`define HBW_BIT_CFG_FAULT  2
`define HBW_BIT_CARD_FAULT 3

// Reset values
`define HBW_RST_WIDE       1'b0
`define HBW_RST_CTL        3'h7

// Pipeline depth from pin to register output, in cycles
`define HBW_PIN_LATENCY    3

`endif

// ==== rtl/hbw_pkg.sv ====
package hbw_pkg;

  // Owner of the card-controller resource
  typedef enum logic [1:0] {
    HBW_FREE,
    HBW_CFG,
    HBW_HOST
  } hbw_owner_t;

  // Arbiter state
  typedef struct packed {
    hbw_owner_t owner;
  } hbw_arb_st_t;

  // Register front-end state
  typedef struct packed {
    logic [6:0]  addr_s1;
    logic [6:0]  addr_s2;
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic [2:0]  ctl_s1;   // {ce_n, oe_n, we_n}
    logic [2:0]  ctl_s2;
    logic        wr_prev;
    logic        wide;
    logic [31:0] stat;
    logic [31:0] fault;
    logic [15:0] dout;
    logic        oe_lo;
    logic        oe_hi;
  } hbw_regs_st_t;

endpackage

// ==== rtl/hbw_lock_if.sv ====
`timescale 1ns/1ps
// Lock requests and grants between front end and arbiter
interface hbw_lock_if;
  logic cfg_req;    // Config engine wants the card controller
  logic host_req;   // Host port wants the card controller
  logic cfg_own;    // Config engine holds the lock
  logic host_own;   // Host port holds the lock

  modport arb (
    input  cfg_req,
    input  host_req,
    output cfg_own,
    output host_own
  );

  modport user (
    output cfg_req,
    output host_req,
    input  cfg_own,
    input  host_own
  );
endinterface

// ==== rtl/hbw_lock_arb.sv ====
`timescale 1ns/1ps
// Single-owner lock on the card-controller resource
module hbw_lock_arb (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_nrst,
  // Requests and grants
  hbw_lock_if.arb   lock
);

  hbw_pkg::hbw_arb_st_t st;       // Registered state
  hbw_pkg::hbw_arb_st_t next_st;  // Next state

  // Grant held until its owner lets go; config wins a tie
  always_comb begin
    next_st = st;
    case (st.owner)
      hbw_pkg::HBW_FREE: begin
        if (lock.cfg_req) begin
          next_st.owner = hbw_pkg::HBW_CFG;
        end else if (lock.host_req) begin
          next_st.owner = hbw_pkg::HBW_HOST;
        end
      end
      hbw_pkg::HBW_CFG: begin
        // Pass through free so grants never overlap
        if (!lock.cfg_req) begin
          next_st.owner = hbw_pkg::HBW_FREE;
        end
      end
      hbw_pkg::HBW_HOST: begin
        if (!lock.host_req) begin
          next_st.owner = hbw_pkg::HBW_FREE;
        end
      end
      default: begin
        next_st.owner = hbw_pkg::HBW_FREE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st.owner <= hbw_pkg::HBW_FREE;
    end else begin
      st <= next_st;
    end
  end

  // One-hot grants decoded from one state
  assign lock.cfg_own  = (st.owner == hbw_pkg::HBW_CFG);   // RL13
  assign lock.host_own = (st.owner == hbw_pkg::HBW_HOST);  // RL13

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_single_owner: assert property (!(lock.cfg_own && lock.host_own)) // RL13
    else $error("both masters hold the card lock");

  a_owner_kept: assert property (
    (lock.host_own && lock.host_req) |=> lock.host_own) // RL13
    else $error("host lock lost while still requested");

endmodule

// ==== sim/hbw_host_model.sv ====
`timescale 1ns/1ps
// Host processor on the parallel port; pins change on falling edges only
module hbw_host_model (
  // Clock
  input  wire logic        i_ref_clk,
  // Pins towards the port
  output logic      [6:0]  o_addr,
  output logic      [15:0] o_data,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  // Pins back from the port
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_oe_lo,
  input  wire logic        i_oe_hi
);
  // Idle strobes from time zero
  initial begin
    o_addr = 7'h00;
    o_data = 16'h0000;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_we_n = 1'b1;
  end

  // Wait n falling edges
  task automatic hold_cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  // One write; pins held well past the sync stages
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    o_addr = a;
    o_data = d;
    hold_cyc(3);
    o_ce_n = 1'b0;
    o_we_n = 1'b0;
    hold_cyc(5);
    o_ce_n = 1'b1;
    o_we_n = 1'b1;
    hold_cyc(4);
    // Released line shows the inverse, not a stale match
    o_data = ~d;
    hold_cyc(1);
  endtask

  // One read; answer taken on a settled edge before release
  task automatic rd(input logic [6:0] a, output logic [15:0] d,
                    output logic lo, output logic hi);
    o_addr = a;
    hold_cyc(3);
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    hold_cyc(5);
    d = i_rdata;
    lo = i_oe_lo;
    hi = i_oe_hi;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    hold_cyc(5);
  endtask
endmodule

// ==== sim/tb_host_bus_width_and_status_bits.sv ====
`timescale 1ns/1ps
// Bench for the host-port width and status registers
module tb_host_bus_width_and_status_bits;
  logic        i_ref_clk;    // 100 MHz
  logic        i_nrst;       // Sync reset, active low
  logic [6:0]  addr;         // Host address pins
  logic [15:0] wdata;        // Host write data
  logic [15:0] rdata;        // Port read data
  logic        ce_n;         // Chip enable
  logic        oe_n;         // Read strobe
  logic        we_n;         // Write strobe
  logic        oe_lo;        // Low byte drive
  logic        oe_hi;        // High byte drive
  logic        cfg_req;      // Config engine lock request
  logic        host_req;     // Host lock request
  logic        cfg_fault;    // Config engine fault
  logic        card_fault;   // Card engine fault
  logic [31:0] fault_detail; // Fault detail word
  logic        wide;         // Width bit output
  logic        mode;         // Expected width
  logic        target;       // Width being written
  logic [31:0] v;            // Assembled register value
  int          seed = 49;    // Fixed seed
  int          n_errors;     // Mismatches
  int          n_compared;   // Comparisons
  int          cyc;          // Cycle count for timeout

  // Clock
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  hbw_regs i_hbw_regs (
    .i_ref_clk        (i_ref_clk),
    .i_nrst           (i_nrst),
    .i_mpu_addr       (addr),
    .i_mpu_data       (wdata),
    .o_mpu_data       (rdata),
    .o_mpu_data_oe_lo (oe_lo),
    .o_mpu_data_oe_hi (oe_hi),
    .i_mpu_ce_n       (ce_n),
    .i_mpu_oe_n       (oe_n),
    .i_mpu_we_n       (we_n),
    .i_cfg_lock_req   (cfg_req),
    .i_host_lock_req  (host_req),
    .i_cfg_fault      (cfg_fault),
    .i_card_fault     (card_fault),
    .i_fault_detail   (fault_detail),
    .o_wide_bus_bit   (wide)
  );

  hbw_host_model i_hbw_host_model (
    .i_ref_clk (i_ref_clk),
    .o_addr    (addr),
    .o_data    (wdata),
    .o_ce_n    (ce_n),
    .o_oe_n    (oe_n),
    .o_we_n    (we_n),
    .i_rdata   (rdata),
    .i_oe_lo   (oe_lo),
    .i_oe_hi   (oe_hi)
  );

  // Verdict and stop
  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Status expected from the engine inputs; config wins a tie
  function automatic logic [31:0] exp_stat();
    return {28'h0, card_fault, cfg_fault, ~cfg_req & host_req, cfg_req};
  endfunction

  // Read a 32-bit register as bytes or words; A0 random in word mode
  task automatic rd32(input logic [6:0] base, output logic [31:0] r);
    logic [15:0] d;
    logic        lo;
    logic        hi;
    logic [6:0]  a;
    r = 32'h0;
    for (int k = 0; k < (mode ? 2 : 4); k++) begin
      a = mode ? (base + 7'(2 * k)) | 7'($random(seed) & 1) : base + 7'(k);
      i_hbw_host_model.rd(a, d, lo, hi);
      chk("oe", {1'b1, mode}, {lo, hi});
      if (mode) begin
        r[16*k +: 16] = d;
      end else begin
        r[8*k +: 8] = d[7:0];
        chk("hi_byte", 8'h00, d[15:8]);
      end
    end
    // Strobes released: lanes off and data back at zero
    chk("idle", 32'h0, {oe_lo, oe_hi, rdata});
  endtask

  // Hang guard, well above the run length
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // Main sequence; inputs move on falling edges
  initial begin
    i_nrst = 1'b0;
    cfg_req = 1'b0;
    host_req = 1'b0;
    cfg_fault = 1'b0;
    card_fault = 1'b0;
    fault_detail = 32'h0;
    mode = 1'b0;
    cyc = 0;
    repeat (16) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    i_hbw_host_model.hold_cyc(3);
    for (int it = 0; it < 16; it++) begin
      // Width read back through its aliases; reserved bytes read 0
      rd32(7'h00, v);
      chk("width_rd", mode ? 32'(mode) : {23'h0, mode, 7'h0, mode}, v);
      // Flip the width through a random alias, from either width
      target = ~mode;
      i_hbw_host_model.wr(7'($random(seed) & 1), {15'($random(seed)), target});
      chk("wide", target, wide);
      mode = target;
      // Status is read-only: a write there leaves the width alone
      i_hbw_host_model.wr(7'h04, 16'($random(seed)));
      chk("wide_kept", mode, wide);
      // Free the lock, then new requests and faults; second pass a tie
      cfg_req = 1'b0;
      host_req = 1'b0;
      i_hbw_host_model.hold_cyc(4);
      cfg_req = (it == 1) | 1'($random(seed));
      host_req = (it == 1) | 1'($random(seed));
      cfg_fault = 1'($random(seed));
      card_fault = 1'($random(seed));
      fault_detail = $random(seed);
      i_hbw_host_model.hold_cyc(4);
      // Status as the host reads it when looking for an interrupt source
      rd32(7'h04, v);
      chk("status", exp_stat(), v);
      rd32(7'h08, v);
      chk("fault", fault_detail, v);
    end
    end_sim();
  end
endmodule
